/* src/lcs_pkg.sv */
// Package for the lithium charge sequencer: constants, states and port bundles
package lcs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SS_STEP_US = 400;
    localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
    localparam int unsigned SEC_CYC = 1000000 * CLK_MHZ;
    localparam int unsigned DETECT_SEC = 3;
    localparam int unsigned OPEN_TEST_SEC = 2;
    localparam logic [15:0] PRECHG_ENTER_CODE = 16'h39e6;
    localparam logic [15:0] PRECHG_EXIT_CODE = 16'h3aea;
    localparam logic [7:0] FAULT_EXIT_PCT = 8'h23;
    localparam logic [4:0] ITARGET_RST = 5'h1f;
    localparam logic [4:0] ABSORB_CLAMP_CODE = 5'h1f;
    localparam logic [4:0] IMIN_CODE = 5'h00;
    localparam int unsigned SEC_W = 27;
    localparam int unsigned SS_W = 16;

    typedef enum logic [9:0] {
        ST_SUSPEND = 10'h001,
        ST_DETECT = 10'h002,
        ST_OPEN_TEST = 10'h004,
        ST_SOFT_START = 10'h008,
        ST_PRECHARGE = 10'h010,
        ST_ABSORB = 10'h020,
        ST_CCCV = 10'h040,
        ST_TERMINATED = 10'h080,
        ST_TIME_FAULT = 10'h100,
        ST_DETECT_FAULT = 10'h200
    } lcs_state_type;

    typedef struct packed {
        logic [15:0] max_charge_time;
        logic [15:0] max_cv_time;
        logic [15:0] max_absorb_time;
        logic [4:0] icharge_target;
        logic [4:0] absorb_voltage_offset;
        logic [4:0] vcharge_setting;
        logic lifepo4;
        logic en_c_over_x_term;
        logic suspend;
        logic detect_fault_mask;
    } lcs_cfg_type;

    typedef struct packed {
        logic [15:0] filtered_battery_voltage_code;
        logic [15:0] battery_current_reading;
        logic [15:0] c_over_x_threshold;
        logic [15:0] vcharge_code;
        logic [15:0] absorb_target_code;
        logic batt_stable;
        logic batt_in_range;
        logic ntc_open;
        logic sense_above_2v6;
        logic sense_below_2v4;
        logic vin_near_bat;
        logic system_fault;
        logic input_current_limiting;
        logic input_uv_limiting;
    } lcs_meas_type;

    typedef struct packed {
        logic [4:0] icharge_dac;
        logic load_1ma;
        logic charger_on;
        logic peak_mode;
        logic precharge;
        logic main_phase_flag;
        logic absorb_flag;
        logic voltage_hold;
        logic icl_flag;
        logic uvcl_flag;
        logic detect_fault;
        logic time_fault;
        logic detect_irq;
        logic [4:0] vtarget;
    } lcs_stat_type;

    function automatic logic [4:0] lcs_sat_add(input logic [4:0] a, input logic [4:0] b);
        logic [5:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > {1'b0, ABSORB_CLAMP_CODE}) ? ABSORB_CLAMP_CODE : s[4:0];
    endfunction
endpackage

/* src/lcs_sequencer.sv */
// Charge-cycle sequencer for lithium chemistries
`timescale 1ns/1ps
// Summary of operation
// - Detection test with 1mA load, seconds long
// - Stable goes soft-start, else brief minimum-current test
// - Open thermistor faults detection; maskable alert
// - Soft-start ramps current one step per 400us
// - Max charge timer from soft-start; faults on expiry
// - Fault exits below 35% charge voltage, timer reset
// - Timer resets on CV or C-over-x termination
// - Low lithium-ion battery precharges at one tenth
// - Precharge ends above exit code, main phase
// - Peak current mode below 2.4V until 2.6V
// - Iron-phosphate skips precharge, full target current
// - Iron-phosphate nonzero offset starts absorb phase
// - Absorb target clamped; hold flag when reached
// - Input limits cut current and raise flags
// - Absorb ends on time or hold plus low current
// - Terminate on CV time, C-over-x, or never
// - Suspend from anywhere on input, software, fault
// - Input limits only reduce, never raise current
module lcs_sequencer
    import lcs_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYC,
    parameter int unsigned SS_CYCLES = SS_STEP_CYC
) (
    input wire logic clk_in, // 100 MHz clock
    input wire logic rstn_in, // Async reset, active low
    input wire lcs_cfg_type cfg_in, // Software configuration
    input wire lcs_meas_type meas_in, // Analog comparator and ADC results
    output lcs_stat_type stat_out // Control and status, registered
);
    // Every register of the sequencer lives in this one struct, so reset and update stay in one place
    typedef struct packed {
        // Phase control
        lcs_state_type st; // Current charge phase
        // Time base
        logic [SEC_W-1:0] sec_cnt; // Clock cycles within the current second
        logic tick; // One-cycle pulse at each second boundary
        logic [SS_W-1:0] ss_cnt; // Clock cycles within the current ramp step
        // Long timers in seconds, saturating so a stalled cycle never wraps to a small count
        logic [15:0] phase_sec; // Seconds spent in the current phase
        logic [15:0] chg_sec; // Seconds of charging since soft-start
        logic chg_run; // Charge timer is counting
        // Pin synchroniser, one bit per asynchronous input
        logic [8:0] sync1; // First stage, may be metastable
        logic [8:0] sync2; // Second stage, safe to read
        // Sense pin hysteresis
        logic pk_mode; // Low-voltage peak current mode latched
        // Registered outputs
        lcs_stat_type stat; // Everything seen on the status port
    } lcs_core_type;

    // Present and next value of the whole state
    lcs_core_type cur_ff; // Registered state
    lcs_core_type nxt_core; // Next state from the decode below

    // Bundle of single-bit pin inputs; these arrive from the analog side asynchronously
    // and are only read after the two-stage synchroniser
    logic [8:0] raw_bits; // Pin inputs before synchronisation
    assign raw_bits = {meas_in.batt_stable, meas_in.batt_in_range, meas_in.ntc_open, meas_in.sense_above_2v6,
                       meas_in.sense_below_2v4, meas_in.vin_near_bat, meas_in.system_fault,
                       meas_in.input_current_limiting, meas_in.input_uv_limiting};

    // Combinational next-state for the whole sequencer
    // Every decision reads the same cycle's inputs, so no two branches can disagree
    always_comb begin
        // Synchronised pin levels
        logic s_stable, s_range, s_ntc, s_hi, s_lo, s_near, s_sysf, s_icl, s_uv;
        // Current code that the next phase asks for
        logic [4:0] base_i;
        // Current code after the input limits have had their say
        logic [4:0] cut_i;
        // Battery code below which a charge-time fault clears
        logic [15:0] fault_limit;
        // Battery has reached the absorb target
        logic hold;
        s_stable = 1'b0;
        s_range = 1'b0;
        s_ntc = 1'b0;
        s_hi = 1'b0;
        s_lo = 1'b0;
        s_near = 1'b0;
        s_sysf = 1'b0;
        s_icl = 1'b0;
        s_uv = 1'b0;
        base_i = 5'h00;
        cut_i = 5'h00;
        fault_limit = 16'h0000;
        hold = 1'b0;
        // Start from holding every register; branches below change only what moves
        nxt_core = cur_ff;
        // Two-stage synchroniser; only the second stage is read below
        // This adds two cycles of latency to every pin decision
        nxt_core.sync1 = raw_bits;
        nxt_core.sync2 = cur_ff.sync1;
        {s_stable, s_range, s_ntc, s_hi, s_lo, s_near, s_sysf, s_icl, s_uv} = cur_ff.sync2;
        // One-second tick from the system clock
        // Free running from reset, so a phase may start anywhere within a second
        nxt_core.tick = 1'b0;
        if (cur_ff.sec_cnt == SEC_W'(SEC_CYCLES - 1)) begin
            nxt_core.sec_cnt = '0;
            nxt_core.tick = 1'b1;
        end else begin
            nxt_core.sec_cnt = cur_ff.sec_cnt + SEC_W'(1);
        end
        // Peak current mode hysteresis on the sense pin
        // Between the two thresholds the last mode is kept, which avoids chatter
        if (s_lo) begin
            nxt_core.pk_mode = 1'b1;
        end else if (s_hi) begin
            nxt_core.pk_mode = 1'b0;
        end
        // Phase timer counts seconds spent in the current state
        // Each state that needs a fresh count clears it on entry
        if (cur_ff.tick) begin
            nxt_core.phase_sec = (cur_ff.phase_sec == 16'hffff) ? cur_ff.phase_sec : cur_ff.phase_sec + 16'h0001;
        end
        // Maximum charge timer runs once soft-start has begun
        // It keeps counting through precharge, absorb and CC-CV
        if (cur_ff.tick && cur_ff.chg_run && cur_ff.chg_sec != 16'hffff) begin
            nxt_core.chg_sec = cur_ff.chg_sec + 16'h0001;
        end
        // Absorb target reached; the target code is supplied by the measurement side
        hold = meas_in.filtered_battery_voltage_code >= meas_in.absorb_target_code;
        // Fault exit level as a fraction of the charge voltage; the product needs 22 bits, so it is widened to 32 before the divide
        fault_limit = 16'((32'(meas_in.vcharge_code) * 32'(FAULT_EXIT_PCT)) / 32'h64);
        case (cur_ff.st)
            // Parked: wait until nothing holds the charger off
            ST_SUSPEND: begin
                nxt_core.chg_run = 1'b0;
                nxt_core.chg_sec = 16'h0000;
                if (!cfg_in.suspend && !s_near && !s_sysf) begin
                    nxt_core.st = ST_DETECT;
                    nxt_core.phase_sec = 16'h0000;
                end
            end

            // Detection load applied; an open thermistor aborts at once
            ST_DETECT: begin
                if (s_ntc) begin
                    nxt_core.st = ST_DETECT_FAULT;
                end else if (cur_ff.phase_sec >= 16'(DETECT_SEC)) begin
                    nxt_core.phase_sec = 16'h0000;
                    nxt_core.ss_cnt = '0;
                    nxt_core.stat.icharge_dac = 5'h00;
                    nxt_core.st = s_stable ? ST_SOFT_START : ST_OPEN_TEST;
                end
            end

            // Minimum-current probe; a battery still out of range is a detection fault
            ST_OPEN_TEST: begin
                if (cur_ff.phase_sec >= 16'(OPEN_TEST_SEC)) begin
                    nxt_core.phase_sec = 16'h0000;
                    nxt_core.stat.icharge_dac = 5'h00;
                    nxt_core.st = s_range ? ST_SOFT_START : ST_DETECT_FAULT;
                end
            end

            // Ramp the applied code up to the target, then pick the charging phase
            ST_SOFT_START: begin
                nxt_core.chg_run = 1'b1;
                if (cur_ff.stat.icharge_dac >= cfg_in.icharge_target) begin
                    nxt_core.phase_sec = 16'h0000;
                    if (!cfg_in.lifepo4 && meas_in.filtered_battery_voltage_code < PRECHG_ENTER_CODE && s_hi) begin
                        nxt_core.st = ST_PRECHARGE;
                    end else if (cfg_in.lifepo4 && cfg_in.absorb_voltage_offset != 5'h00) begin
                        nxt_core.st = ST_ABSORB;
                    end else begin
                        nxt_core.st = ST_CCCV;
                    end
                end else if (s_icl || s_uv) begin
                    // An active input limit freezes the ramp instead of letting it climb past the limit
                    nxt_core.ss_cnt = '0;
                end else if (cur_ff.ss_cnt == SS_W'(SS_CYCLES - 1)) begin
                    nxt_core.ss_cnt = '0;
                    nxt_core.stat.icharge_dac = cur_ff.stat.icharge_dac + 5'h01;
                end else begin
                    nxt_core.ss_cnt = cur_ff.ss_cnt + SS_W'(1);
                end
            end

            // Reduced current until the battery climbs past the exit code
            ST_PRECHARGE: begin
                if (meas_in.filtered_battery_voltage_code > PRECHG_EXIT_CODE) begin
                    nxt_core.st = ST_CCCV;
                    nxt_core.phase_sec = 16'h0000;
                end
            end

            // Lifted voltage target at full current; ends on time or on hold with low current
            ST_ABSORB: begin
                if (cur_ff.phase_sec >= cfg_in.max_absorb_time ||
                    (hold && meas_in.battery_current_reading < meas_in.c_over_x_threshold)) begin
                    nxt_core.st = ST_CCCV;
                    nxt_core.phase_sec = 16'h0000;
                end
            end

            // Normal charging; ends on CV time or the current fraction, or never when both are off
            ST_CCCV: begin
                // CV timer only runs while the battery sits at the charge voltage
                if (meas_in.filtered_battery_voltage_code < meas_in.vcharge_code) begin
                    nxt_core.phase_sec = 16'h0000;
                end
                // First term: current fraction, only when enabled and at the charge voltage
                // Second term: CV timer, which iron-phosphate disables with a zero limit
                if ((cfg_in.en_c_over_x_term && meas_in.filtered_battery_voltage_code >= meas_in.vcharge_code &&
                     meas_in.battery_current_reading < meas_in.c_over_x_threshold) ||
                    ((!cfg_in.lifepo4 || cfg_in.max_cv_time != 16'h0000) &&
                     meas_in.filtered_battery_voltage_code >= meas_in.vcharge_code &&
                     cur_ff.phase_sec >= cfg_in.max_cv_time)) begin
                    nxt_core.st = ST_TERMINATED;
                    nxt_core.chg_run = 1'b0;
                    nxt_core.chg_sec = 16'h0000;
                end
            end

            // Cycle complete; only a global exit starts a new one
            ST_TERMINATED: begin
                nxt_core.chg_run = 1'b0;
            end

            // Safety timer expired; a deeply sagging battery starts a fresh cycle
            ST_TIME_FAULT: begin
                nxt_core.chg_run = 1'b0;
                if (meas_in.filtered_battery_voltage_code < fault_limit) begin
                    nxt_core.st = ST_DETECT;
                    nxt_core.chg_sec = 16'h0000;
                    nxt_core.phase_sec = 16'h0000;
                end
            end

            // No usable battery; only a global exit clears it
            ST_DETECT_FAULT: begin
                nxt_core.chg_run = 1'b0;
            end

            // Unreachable with one-hot codes; recover to the safe state
            default: begin
                nxt_core.st = ST_SUSPEND;
            end
        endcase
        // Charge time limit overrides the active charging phases
        // Terminated and the time-fault state are excluded so the timer cannot re-enter a fault
        if (cur_ff.chg_run && cur_ff.chg_sec > cfg_in.max_charge_time &&
            cur_ff.st != ST_TERMINATED && cur_ff.st != ST_TIME_FAULT) begin
            nxt_core.st = ST_TIME_FAULT;
            nxt_core.chg_run = 1'b0;
        end
        // Global exits win over every state, including both fault states
        // They come last so that no phase decision above can override them
        if (s_near || cfg_in.suspend || s_sysf) begin
            nxt_core.st = ST_SUSPEND;
            nxt_core.chg_run = 1'b0;
        end
        // Outputs decoded from the next state so they leave a flip-flop
        case (nxt_core.st)
            ST_PRECHARGE: base_i = cfg_in.icharge_target / 5'h0a;
            ST_ABSORB, ST_CCCV: base_i = cfg_in.icharge_target;
            ST_OPEN_TEST: base_i = IMIN_CODE;
            default: base_i = 5'h00;
        endcase
        // Input limits step current down only; never above the base
        // One code per clock is a coarse stand-in for the analog loop settling at the limit
        cut_i = base_i;
        if ((s_icl || s_uv) && cur_ff.stat.icharge_dac < base_i) begin
            cut_i = cur_ff.stat.icharge_dac;
        end
        if ((s_icl || s_uv) && cut_i != 5'h00) begin
            cut_i = cut_i - 5'h01;
        end
        if (nxt_core.st != ST_SOFT_START) begin
            nxt_core.stat.icharge_dac = cut_i;
        end
        // Status follows the next state, so flags and the applied code change on the same edge
        nxt_core.stat.load_1ma = nxt_core.st == ST_DETECT;
        nxt_core.stat.charger_on = nxt_core.st == ST_OPEN_TEST || nxt_core.st == ST_SOFT_START ||
                                   nxt_core.st == ST_PRECHARGE || nxt_core.st == ST_ABSORB || nxt_core.st == ST_CCCV;
        nxt_core.stat.peak_mode = nxt_core.pk_mode && nxt_core.stat.charger_on;
        nxt_core.stat.precharge = nxt_core.st == ST_PRECHARGE;
        nxt_core.stat.main_phase_flag = nxt_core.st == ST_CCCV;
        nxt_core.stat.absorb_flag = nxt_core.st == ST_ABSORB;
        // Absorb voltage target code, reported for software
        nxt_core.stat.vtarget = lcs_sat_add(cfg_in.vcharge_setting, cfg_in.absorb_voltage_offset);
        nxt_core.stat.voltage_hold = (nxt_core.st == ST_ABSORB) ? hold :
            (nxt_core.st == ST_CCCV && meas_in.filtered_battery_voltage_code >= meas_in.vcharge_code);
        // Limit flags only mean something while the switcher runs
        nxt_core.stat.icl_flag = s_icl && nxt_core.stat.charger_on;
        nxt_core.stat.uvcl_flag = s_uv && nxt_core.stat.charger_on;
        // Fault flags and the maskable alert
        nxt_core.stat.detect_fault = nxt_core.st == ST_DETECT_FAULT;
        nxt_core.stat.time_fault = nxt_core.st == ST_TIME_FAULT;
        nxt_core.stat.detect_irq = nxt_core.stat.detect_fault && !cfg_in.detect_fault_mask;
    end

    // State register; reset parks the charger in suspend with all drive off
    // Reset values are constants only; the synchroniser restarts empty
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur_ff <= '{st: ST_SUSPEND, default: '0};
        end else begin
            cur_ff <= nxt_core;
        end
    end

    // Status leaves straight from the state register
    assign stat_out = cur_ff.stat;
endmodule

/* verif/lcs_sequencer_sva.sv */
// Port-level assertion checker for the lithium charge sequencer
`timescale 1ns/1ps
module lcs_sequencer_sva
    import lcs_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYC, // Clock cycles per second tick
    parameter int unsigned SS_CYCLES = SS_STEP_CYC // Clock cycles per ramp step
) (
    input wire logic clk_in, // Clock
    input wire logic rstn_in, // Async reset, active low
    input wire lcs_cfg_type cfg_in, // Software configuration
    input wire lcs_meas_type meas_in, // Measurement inputs
    input wire lcs_stat_type stat_out // Status outputs
);
    logic [1:0] up_ff; // Cycles since reset, saturating
    logic ready; // History-based checks may run
    // Past values straddling a reset are not trusted, so wait a few edges
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_ff <= 2'h0;
        end else if (up_ff != 2'h3) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    assign ready = (up_ff == 2'h3);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    AST_SUSPEND_CFG: assert property (cfg_in.suspend |-> ##[1:2] !stat_out.charger_on)
        else $error("charger on after suspend request");
    AST_SUSPEND_NEAR: assert property (meas_in.vin_near_bat |-> ##[1:4] !stat_out.charger_on)
        else $error("charger on with input near battery");
    AST_PRECHG_DAC: assert property (stat_out.precharge |-> stat_out.icharge_dac <= cfg_in.icharge_target / 5'h0a)
        else $error("precharge current above one tenth");
    AST_LIMIT_NO_RISE: assert property ((ready && (stat_out.icl_flag || stat_out.uvcl_flag)) [*2]
        |-> stat_out.icharge_dac <= $past(stat_out.icharge_dac)) else $error("current rose while limited");
    AST_TIME_FAULT_OFF: assert property (stat_out.time_fault |-> !stat_out.charger_on)
        else $error("charging during time fault");
    AST_VTARGET: assert property (ready && $stable(cfg_in.vcharge_setting) && $stable(cfg_in.absorb_voltage_offset)
        |-> stat_out.vtarget == ((6'(cfg_in.vcharge_setting) + 6'(cfg_in.absorb_voltage_offset) > 6'h1f) ? 5'h1f
        : cfg_in.vcharge_setting + cfg_in.absorb_voltage_offset)) else $error("absorb target wrong");
    AST_IRQ_RAISE: assert property ((ready && stat_out.detect_fault && !cfg_in.detect_fault_mask) [*2]
        |-> stat_out.detect_irq) else $error("detection alert missing");
    AST_IRQ_MASK: assert property ((ready && cfg_in.detect_fault_mask) [*2] |-> !stat_out.detect_irq)
        else $error("masked alert raised");
    cover property (stat_out.precharge);
    cover property (stat_out.time_fault);
    cover property (stat_out.absorb_flag);
endmodule
bind lcs_sequencer lcs_sequencer_sva #(.SEC_CYCLES(SEC_CYCLES), .SS_CYCLES(SS_CYCLES)) u_sva (
    .clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg_in), .meas_in(meas_in), .stat_out(stat_out));

/* verif/lcs_sequencer_tb_top.sv */
// Self-checking bench for the lithium charge sequencer
`timescale 1ns/1ps
module lcs_sequencer_tb_top
    import lcs_pkg::*;
;
    logic clk_in = 1'b0; // 100 MHz clock
    logic rstn_in = 1'b0; // Reset, active low
    lcs_cfg_type cfg; // Configuration drive
    lcs_meas_type meas; // Measurement drive
    lcs_stat_type stat; // Observed status
    int n_fail = 0; // Mismatch count
    int comparisons = 0; // Compare count
    int cycles = 0; // Watchdog count
    always #5 clk_in = ~clk_in;
    // Short second and ramp step keep the run to a few thousand cycles
    lcs_sequencer #(.SEC_CYCLES(100), .SS_CYCLES(4)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg),
        .meas_in(meas), .stat_out(stat));
    // Ends on an edge so that following drives land on it
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Step past the edge so registered outputs have settled
    task automatic at(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Suspend then release starts a fresh cycle from detection
    task automatic start();
        cfg.suspend <= 1'b1;
        cyc(4);
        cfg.suspend <= 1'b0;
    endtask
    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Run is about 4000 cycles; the ceiling leaves ample margin
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("ERROR %0t watchdog expired", $time);
            stop_test();
        end
    end
    initial begin
        cfg = '{max_charge_time:16'hffff, max_cv_time:16'h0002, max_absorb_time:16'hffff, icharge_target:5'h0a,
            vcharge_setting:5'h10, default:'0};
        meas = '{filtered_battery_voltage_code:16'h3000, battery_current_reading:16'h0200,
            c_over_x_threshold:16'h0100, vcharge_code:16'h4000, absorb_target_code:16'h4800, batt_stable:1'b1,
            batt_in_range:1'b1, sense_above_2v6:1'b1, default:'0};
        at(2);
        chk(5'(stat == '0), 5'h01);
        cyc(1);
        rstn_in <= 1'b1;
        start();
        at(150);
        chk(5'(stat.load_1ma), 5'h01);
        at(158);
        chk(stat.icharge_dac, 5'h02);
        chk(5'(stat.charger_on), 5'h01);
        at(142);
        chk(5'(stat.precharge), 5'h01);
        chk(stat.icharge_dac, 5'h01);
        cyc(1);
        meas.filtered_battery_voltage_code <= PRECHG_EXIT_CODE;
        at(5);
        chk(5'(stat.precharge), 5'h01);
        cyc(1);
        meas.filtered_battery_voltage_code <= 16'h3aeb;
        at(5);
        chk(5'(stat.main_phase_flag), 5'h01);
        chk(stat.icharge_dac, 5'h0a);
        cyc(1);
        meas.input_current_limiting <= 1'b1;
        at(20);
        chk(5'(stat.icl_flag), 5'h01);
        chk(stat.icharge_dac, 5'h00);
        cyc(1);
        meas.input_current_limiting <= 1'b0;
        meas.input_uv_limiting <= 1'b1;
        at(20);
        chk({stat.icl_flag, stat.uvcl_flag}, 5'h01);
        cyc(1);
        meas.input_uv_limiting <= 1'b0;
        meas.sense_below_2v4 <= 1'b1;
        meas.sense_above_2v6 <= 1'b0;
        at(20);
        chk(5'(stat.peak_mode), 5'h01);
        cyc(1);
        meas.sense_below_2v4 <= 1'b0;
        at(20);
        chk(5'(stat.peak_mode), 5'h01);
        cyc(1);
        meas.sense_above_2v6 <= 1'b1;
        meas.filtered_battery_voltage_code <= 16'h4000;
        at(20);
        chk({stat.peak_mode, stat.icharge_dac[3:0]}, 5'h0a);
        at(400);
        chk(5'(stat.charger_on), 5'h00);
        cyc(1);
        cfg.max_charge_time <= 16'h0001;
        meas.filtered_battery_voltage_code <= 16'h3000;
        start();
        at(700);
        chk({stat.time_fault, stat.charger_on}, 5'h02);
        cyc(1);
        meas.filtered_battery_voltage_code <= 16'h1666;
        at(5);
        chk(5'(stat.time_fault), 5'h01);
        cyc(1);
        meas.filtered_battery_voltage_code <= 16'h1665;
        at(5);
        chk({stat.time_fault, stat.load_1ma}, 5'h01);
        cyc(1);
        meas.vin_near_bat <= 1'b1;
        at(6);
        chk(5'(stat.load_1ma), 5'h00);
        cyc(1);
        meas.vin_near_bat <= 1'b0;
        meas.batt_stable <= 1'b0;
        meas.batt_in_range <= 1'b0;
        cfg.max_charge_time <= 16'hffff;
        start();
        at(600);
        chk({stat.detect_fault, stat.detect_irq}, 5'h03);
        cyc(1);
        cfg.detect_fault_mask <= 1'b1;
        at(3);
        chk(5'(stat.detect_irq), 5'h00);
        cyc(1);
        meas.batt_stable <= 1'b1;
        meas.batt_in_range <= 1'b1;
        meas.ntc_open <= 1'b1;
        start();
        at(600);
        chk(5'(stat.detect_fault), 5'h01);
        cyc(1);
        meas.system_fault <= 1'b1;
        at(5);
        chk(5'(stat.detect_fault), 5'h00);
        cyc(1);
        meas.system_fault <= 1'b0;
        meas.ntc_open <= 1'b0;
        cfg.lifepo4 <= 1'b1;
        cfg.absorb_voltage_offset <= 5'h1f;
        start();
        at(460);
        chk(stat.vtarget, 5'h1f);
        chk({stat.absorb_flag, stat.precharge}, 5'h02);
        chk(stat.icharge_dac, 5'h0a);
        cyc(1);
        meas.filtered_battery_voltage_code <= 16'h4800;
        at(5);
        chk({stat.voltage_hold, stat.absorb_flag}, 5'h03);
        cyc(1);
        meas.battery_current_reading <= 16'h0000;
        at(5);
        chk(5'(stat.main_phase_flag), 5'h01);
        cyc(1);
        cfg.max_cv_time <= 16'h0000;
        at(400);
        chk(5'(stat.charger_on), 5'h01);
        cyc(1);
        cfg.en_c_over_x_term <= 1'b1;
        at(6);
        chk(5'(stat.charger_on), 5'h00);
        stop_test();
    end
endmodule
